//--- inc/msq_pkg.sv
package msq_pkg;

    // Clock and timing
    localparam int CLK_HZ = 200_000_000;
    localparam int HOLD_MS = 10;
    localparam int HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
    // Object type changeover time in cycles (no documented figure)
    localparam int CHG_CYC = 16;

    // Widths
    localparam int OBJ_W = 4;
    localparam int RES_W = 8;
    localparam int CODE_W = 8;
    localparam int PSEL_W = 2;
    localparam int PIN_W = 1 + OBJ_W + PSEL_W;
    localparam int TIME_W = 32;

    // Serial command codes
    localparam logic [CODE_W-1:0] CMD_EXEC_LO = 8'h10;
    localparam logic [CODE_W-1:0] CMD_EXEC_HI = 8'h13;
    localparam logic [CODE_W-1:0] CMD_RESULT = 8'h11;
    localparam logic [CODE_W-1:0] CMD_ARM_LO = 8'h18;
    localparam logic [CODE_W-1:0] CMD_ARM_HI = 8'h1b;

    // Link and device error codes
    localparam logic [CODE_W-1:0] ERR_NONE = 8'h00;
    localparam logic [CODE_W-1:0] ERR_WRITE_MODE = 8'h10;
    // Trigger not configured, error number 34
    localparam logic [CODE_W-1:0] ERR_TRIG_UNSET = 8'h22;

    localparam logic [RES_W-1:0] RES_OFF = 8'h00;
    localparam logic [PSEL_W-1:0] PSEL_NONE = 2'h0;

    typedef enum logic [1:0] {
        SRC_PARALLEL = 2'b00,
        SRC_SERIAL = 2'b01,
        SRC_TRIGGER = 2'b10
    } msq_src_t;

    typedef enum logic [1:0] {
        ARM_AUTO = 2'b00,
        ARM_PARALLEL = 2'b01,
        ARM_SERIAL = 2'b10
    } msq_arm_t;

    typedef enum logic [1:0] {
        OUT_NONE = 2'b00,
        OUT_LINK = 2'b01,
        OUT_SERIAL = 2'b10
    } msq_route_t;

    typedef enum logic {
        LINK_WRITE_ENABLE = 1'b0,
        LINK_RESULT_WRITE = 1'b1
    } msq_link_t;

endpackage

//--- inc/msq_if.sv
`timescale 1ns/10ps
interface msq_if;
    import msq_pkg::*;

    // Parallel pins
    logic meas_start_input;
    logic [OBJ_W-1:0] object_type_select_inputs;
    logic program_select_a;
    logic program_select_b;
    logic busy;
    logic [RES_W-1:0] parallel_result_outputs;
    // General-purpose serial
    logic cmd_valid;
    logic [CODE_W-1:0] cmd_code;
    logic resp_valid;
    logic [RES_W-1:0] resp_data;
    // Computer link
    logic link_valid;
    msq_link_t link_cmd;
    logic [RES_W-1:0] link_data;
    logic link_ack;
    logic [CODE_W-1:0] link_err;

    modport dev (
        input meas_start_input, object_type_select_inputs, program_select_a,
        input program_select_b, cmd_valid, cmd_code, link_ack, link_err,
        output busy, parallel_result_outputs, resp_valid, resp_data,
        output link_valid, link_cmd, link_data
    );

    modport host (
        output meas_start_input, object_type_select_inputs, program_select_a,
        output program_select_b, cmd_valid, cmd_code, link_ack, link_err,
        input busy, parallel_result_outputs, resp_valid, resp_data,
        input link_valid, link_cmd, link_data
    );

endinterface

//--- logic/msq_sync.sv
`timescale 1ns/10ps
module msq_sync
    import msq_pkg::*;
#(
    parameter int W = PIN_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end

endmodule

//--- logic/msq_dev.sv
`timescale 1ns/10ps
module msq_dev
    import msq_pkg::*;
#(
    parameter int CHG_CYCLES = CHG_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Controller side
    msq_if.dev bus,
    // Configuration
    input wire msq_src_t start_source_select,
    input wire msq_arm_t sampling_arm_source,
    input wire msq_route_t result_route,
    input wire logic trigger_window_set,
    input wire logic program_switch_en,
    // Measurement engine
    input wire logic trigger_event,
    input wire logic meas_done,
    input wire logic [RES_W-1:0] meas_value,
    output logic meas_go,
    output logic [OBJ_W-1:0] object_type,
    output logic [PSEL_W-1:0] meas_program,
    output logic [TIME_W-1:0] meas_time,
    // Status
    output logic logic_prog_run,
    output logic measurement_done_flag,
    output logic aux_relay_clear,
    output logic sampling,
    output logic trigger_unconfigured_error,
    output logic [CODE_W-1:0] error_code
);

    localparam int CW = $clog2(CHG_CYCLES + 1);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_CHANGE = 3'b010,
        ST_MEAS = 3'b011,
        ST_WAIT = 3'b100,
        ST_RESP = 3'b101,
        ST_LINK_RES = 3'b110,
        ST_LINK_WE = 3'b111
    } msq_dst_t;

    logic [PIN_W-1:0] pins_s;
    logic start_s;
    logic [OBJ_W-1:0] obj_s;
    logic [PSEL_W-1:0] psel_s;
    logic start_rise;
    logic cmd_exec;
    logic cmd_arm;
    logic cmd_res;
    logic arm;

    msq_dst_t state_r, state_nxt;
    logic start_q_r, start_q_nxt;
    logic [OBJ_W-1:0] obj_r, obj_nxt;
    logic [PSEL_W-1:0] prog_r, prog_nxt;
    logic [RES_W-1:0] par_r, par_nxt;
    logic [RES_W-1:0] result_r, result_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [TIME_W-1:0] time_r, time_nxt;
    logic we_pend_r, we_pend_nxt;
    logic retry_r, retry_nxt;
    logic sent_r, sent_nxt;
    logic resp_req_r, resp_req_nxt;
    msq_route_t route_q_r, route_q_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic aux_r, aux_nxt;
    logic resp_v_r, resp_v_nxt;
    logic err_r, err_nxt;

    msq_sync #(
        .W(PIN_W)
    ) u_sync (
        .clock(clock),
        .nrst(nrst),
        .d({bus.meas_start_input, bus.object_type_select_inputs,
            bus.program_select_b, bus.program_select_a}),
        .q(pins_s)
    );

    assign start_s = pins_s[PIN_W-1];
    assign obj_s = pins_s[PSEL_W +: OBJ_W];
    assign psel_s = program_switch_en ? pins_s[PSEL_W-1:0] : PSEL_NONE;
    assign start_rise = start_s && !start_q_r;
    assign cmd_exec = bus.cmd_valid && bus.cmd_code >= CMD_EXEC_LO
        && bus.cmd_code <= CMD_EXEC_HI;
    assign cmd_arm = bus.cmd_valid && bus.cmd_code >= CMD_ARM_LO
        && bus.cmd_code <= CMD_ARM_HI;
    assign cmd_res = bus.cmd_valid && bus.cmd_code == CMD_RESULT;
    // Arming event per sampling source
    assign arm = (sampling_arm_source == ARM_AUTO)
        || (sampling_arm_source == ARM_PARALLEL && start_rise)
        || (sampling_arm_source == ARM_SERIAL && cmd_arm);

    always_comb begin
        state_nxt = state_r;
        start_q_nxt = start_s;
        obj_nxt = obj_r;
        prog_nxt = prog_r;
        par_nxt = par_r;
        result_nxt = result_r;
        cnt_nxt = cnt_r;
        time_nxt = time_r;
        we_pend_nxt = we_pend_r;
        retry_nxt = retry_r;
        sent_nxt = sent_r;
        route_q_nxt = result_route;
        done_nxt = 1'b0;
        aux_nxt = 1'b0;
        resp_v_nxt = 1'b0;
        resp_req_nxt = resp_req_r || cmd_res;
        err_nxt = start_source_select == SRC_TRIGGER && !trigger_window_set;
        if (route_q_r == OUT_SERIAL && result_route == OUT_LINK) begin
            we_pend_nxt = 1'b1;
        end
        unique case (state_r)
            ST_IDLE: begin
                cnt_nxt = '0;
                if (we_pend_r && result_route == OUT_LINK) begin
                    state_nxt = ST_LINK_WE;
                    sent_nxt = 1'b0;
                end else if (start_source_select == SRC_PARALLEL && start_rise) begin
                    obj_nxt = obj_s;
                    prog_nxt = psel_s;
                    time_nxt = '0;
                    state_nxt = (obj_s != obj_r) ? ST_CHANGE : ST_MEAS;
                end else if (start_source_select == SRC_SERIAL && cmd_exec) begin
                    prog_nxt = psel_s;
                    time_nxt = '0;
                    state_nxt = ST_MEAS;
                end else if (start_source_select == SRC_TRIGGER && !err_nxt && arm) begin
                    if (sampling_arm_source == ARM_PARALLEL) begin
                        obj_nxt = obj_s;
                    end
                    prog_nxt = psel_s;
                    state_nxt = (sampling_arm_source == ARM_PARALLEL && obj_s != obj_r)
                        ? ST_CHANGE : ST_SAMPLE;
                end
                if (state_nxt == ST_CHANGE) begin
                    par_nxt = RES_OFF;
                    aux_nxt = 1'b1;
                end
            end
            ST_CHANGE: begin
                cnt_nxt = cnt_r + 1'b1;
                if (start_source_select == SRC_PARALLEL) begin
                    time_nxt = time_r + 1'b1;
                end
                if (cnt_r == CW'(CHG_CYCLES - 1)) begin
                    state_nxt = (start_source_select == SRC_TRIGGER) ? ST_SAMPLE : ST_MEAS;
                end
            end
            ST_SAMPLE: begin
                if (sampling_arm_source == ARM_PARALLEL && !start_s) begin
                    state_nxt = ST_IDLE;
                end else if (sampling_arm_source == ARM_SERIAL && cmd_arm) begin
                    state_nxt = ST_IDLE;
                end else if (trigger_event) begin
                    time_nxt = '0;
                    state_nxt = ST_MEAS;
                end
            end
            ST_MEAS: begin
                time_nxt = time_r + 1'b1;
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                time_nxt = time_r + 1'b1;
                if (meas_done) begin
                    result_nxt = meas_value;
                    par_nxt = meas_value;
                    done_nxt = 1'b1;
                    sent_nxt = 1'b0;
                    unique case (result_route)
                        OUT_LINK: state_nxt = ST_LINK_RES;
                        OUT_SERIAL: state_nxt = ST_RESP;
                        default: state_nxt = ST_IDLE;
                    endcase
                end
            end
            ST_RESP: begin
                if (resp_req_nxt) begin
                    resp_v_nxt = 1'b1;
                    resp_req_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            ST_LINK_RES: begin
                sent_nxt = 1'b1;
                if (bus.link_ack) begin
                    if (bus.link_err == ERR_WRITE_MODE) begin
                        retry_nxt = 1'b1;
                        sent_nxt = 1'b0;
                        state_nxt = ST_LINK_WE;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_LINK_WE: begin
                sent_nxt = 1'b1;
                if (bus.link_ack) begin
                    we_pend_nxt = 1'b0;
                    retry_nxt = 1'b0;
                    sent_nxt = 1'b0;
                    state_nxt = retry_r ? ST_LINK_RES : ST_IDLE;
                end
            end
        endcase
        // Busy covers accepted start through finished result output
        busy_nxt = state_nxt != ST_IDLE && state_nxt != ST_SAMPLE;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            start_q_r <= 1'b0;
            obj_r <= '0;
            prog_r <= PSEL_NONE;
            par_r <= RES_OFF;
            result_r <= RES_OFF;
            cnt_r <= '0;
            time_r <= '0;
            we_pend_r <= 1'b1;
            retry_r <= 1'b0;
            sent_r <= 1'b0;
            resp_req_r <= 1'b0;
            route_q_r <= OUT_NONE;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            aux_r <= 1'b0;
            resp_v_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_q_r <= start_q_nxt;
            obj_r <= obj_nxt;
            prog_r <= prog_nxt;
            par_r <= par_nxt;
            result_r <= result_nxt;
            cnt_r <= cnt_nxt;
            time_r <= time_nxt;
            we_pend_r <= we_pend_nxt;
            retry_r <= retry_nxt;
            sent_r <= sent_nxt;
            resp_req_r <= resp_req_nxt;
            route_q_r <= route_q_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            aux_r <= aux_nxt;
            resp_v_r <= resp_v_nxt;
            err_r <= err_nxt;
        end
    end

    assign bus.busy = busy_r;
    assign bus.parallel_result_outputs = par_r;
    assign bus.resp_valid = resp_v_r;
    assign bus.resp_data = result_r;
    assign bus.link_valid = (state_r == ST_LINK_RES || state_r == ST_LINK_WE) && !sent_r;
    assign bus.link_cmd = (state_r == ST_LINK_WE) ? LINK_WRITE_ENABLE : LINK_RESULT_WRITE;
    assign bus.link_data = result_r;
    assign meas_go = state_r == ST_MEAS;
    assign object_type = obj_r;
    assign meas_program = prog_r;
    assign meas_time = time_r;
    // Logic program halted while measuring
    assign logic_prog_run = !(state_r == ST_CHANGE || state_r == ST_MEAS
        || state_r == ST_WAIT);
    assign measurement_done_flag = done_r;
    assign aux_relay_clear = aux_r;
    assign sampling = state_r == ST_SAMPLE;
    assign trigger_unconfigured_error = err_r;
    assign error_code = err_r ? ERR_TRIG_UNSET : ERR_NONE;

endmodule

//--- logic/msq_host.sv
`timescale 1ns/10ps
module msq_host
    import msq_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Device side
    msq_if.host bus,
    // Parallel start requests
    input wire logic start_req,
    input wire logic [OBJ_W-1:0] obj_type_req,
    input wire logic [PSEL_W-1:0] prog_sel_req,
    output logic seq_ready,
    // Serial commands
    input wire logic cmd_req,
    input wire logic [CODE_W-1:0] cmd_req_code,
    output logic serial_result_valid,
    output logic [RES_W-1:0] serial_result_data,
    // Controller memory side of the link
    input wire logic pc_power_lost,
    output logic link_write_valid,
    output logic [RES_W-1:0] link_write_data,
    // Device status
    output logic dev_busy,
    output logic [RES_W-1:0] dev_result
);

    localparam int HW = $clog2(HOLD_CYCLES + 1);

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SETUP = 2'b01,
        H_HIGH = 2'b10,
        H_LOW = 2'b11
    } msq_hst_t;

    msq_hst_t hst_r, hst_nxt;
    logic [HW-1:0] cnt_r, cnt_nxt;
    logic start_r, start_nxt;
    logic [OBJ_W-1:0] obj_r, obj_nxt;
    logic [PSEL_W-1:0] psel_r, psel_nxt;
    logic cmd_v_r, cmd_v_nxt;
    logic [CODE_W-1:0] cmd_c_r, cmd_c_nxt;
    logic ack_r, ack_nxt;
    logic [CODE_W-1:0] err_r, err_nxt;
    logic we_ok_r, we_ok_nxt;
    logic lw_v_r, lw_v_nxt;
    logic [RES_W-1:0] lw_d_r, lw_d_nxt;
    logic res_v_r, res_v_nxt;
    logic [RES_W-1:0] res_d_r, res_d_nxt;
    logic busy_r, busy_nxt;
    logic [RES_W-1:0] par_r, par_nxt;
    logic hold_end;

    assign hold_end = cnt_r == HW'(HOLD_CYCLES - 1);

    always_comb begin
        hst_nxt = hst_r;
        cnt_nxt = cnt_r + 1'b1;
        start_nxt = start_r;
        obj_nxt = obj_r;
        psel_nxt = prog_sel_req;
        cmd_v_nxt = cmd_req;
        cmd_c_nxt = cmd_req ? cmd_req_code : cmd_c_r;
        ack_nxt = bus.link_valid;
        err_nxt = (bus.link_cmd == LINK_RESULT_WRITE && !we_ok_r) ? ERR_WRITE_MODE : ERR_NONE;
        we_ok_nxt = we_ok_r && !pc_power_lost;
        if (bus.link_valid && bus.link_cmd == LINK_WRITE_ENABLE) begin
            we_ok_nxt = 1'b1;
        end
        lw_v_nxt = bus.link_valid && bus.link_cmd == LINK_RESULT_WRITE && we_ok_r;
        lw_d_nxt = bus.link_valid ? bus.link_data : lw_d_r;
        res_v_nxt = bus.resp_valid;
        res_d_nxt = bus.resp_valid ? bus.resp_data : res_d_r;
        busy_nxt = bus.busy;
        par_nxt = bus.parallel_result_outputs;
        unique case (hst_r)
            H_IDLE: begin
                cnt_nxt = '0;
                if (start_req) begin
                    obj_nxt = obj_type_req;
                    hst_nxt = H_SETUP;
                end
            end
            H_SETUP: begin
                if (hold_end) begin
                    cnt_nxt = '0;
                    start_nxt = 1'b1;
                    hst_nxt = H_HIGH;
                end
            end
            H_HIGH: begin
                if (hold_end) begin
                    cnt_nxt = '0;
                    start_nxt = 1'b0;
                    hst_nxt = H_LOW;
                end
            end
            H_LOW: begin
                if (hold_end) begin
                    hst_nxt = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            hst_r <= H_IDLE;
            cnt_r <= '0;
            start_r <= 1'b0;
            obj_r <= '0;
            psel_r <= PSEL_NONE;
            cmd_v_r <= 1'b0;
            cmd_c_r <= '0;
            ack_r <= 1'b0;
            err_r <= ERR_NONE;
            we_ok_r <= 1'b0;
            lw_v_r <= 1'b0;
            lw_d_r <= RES_OFF;
            res_v_r <= 1'b0;
            res_d_r <= RES_OFF;
            busy_r <= 1'b0;
            par_r <= RES_OFF;
        end else begin
            hst_r <= hst_nxt;
            cnt_r <= cnt_nxt;
            start_r <= start_nxt;
            obj_r <= obj_nxt;
            psel_r <= psel_nxt;
            cmd_v_r <= cmd_v_nxt;
            cmd_c_r <= cmd_c_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            we_ok_r <= we_ok_nxt;
            lw_v_r <= lw_v_nxt;
            lw_d_r <= lw_d_nxt;
            res_v_r <= res_v_nxt;
            res_d_r <= res_d_nxt;
            busy_r <= busy_nxt;
            par_r <= par_nxt;
        end
    end

    assign bus.meas_start_input = start_r;
    assign bus.object_type_select_inputs = obj_r;
    assign bus.program_select_a = psel_r[0];
    assign bus.program_select_b = psel_r[1];
    assign bus.cmd_valid = cmd_v_r;
    assign bus.cmd_code = cmd_c_r;
    assign bus.link_ack = ack_r;
    assign bus.link_err = err_r;
    assign seq_ready = hst_r == H_IDLE;
    assign serial_result_valid = res_v_r;
    assign serial_result_data = res_d_r;
    assign link_write_valid = lw_v_r;
    assign link_write_data = lw_d_r;
    assign dev_busy = busy_r;
    assign dev_result = par_r;

endmodule

//--- test/msq_chk.sv
`timescale 1ns/10ps
module msq_chk
    import msq_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Interface signals
    input wire logic meas_start_input,
    input wire logic busy,
    input wire logic resp_valid,
    input wire logic link_valid,
    input wire msq_link_t link_cmd,
    input wire logic link_ack,
    input wire logic [CODE_W-1:0] link_err,
    // Device status
    input wire logic sampling
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    pwrup_write_enable_a: assert property ($rose(nrst) |-> ##[0:3]
        (link_valid && link_cmd == LINK_WRITE_ENABLE)) else $error("no write enable after reset");
    link_ack_follows_a: assert property (link_valid |=> link_ack)
        else $error("link command not acknowledged");
    link_ack_cause_a: assert property (link_ack |-> $past(link_valid))
        else $error("acknowledge without command");
    write_retry_a: assert property (link_ack && link_err == ERR_WRITE_MODE |=>
        (link_valid && link_cmd == LINK_WRITE_ENABLE) ##2
        (link_valid && link_cmd == LINK_RESULT_WRITE)) else $error("no retry after error");
    resp_pulse_a: assert property (resp_valid |=> !resp_valid)
        else $error("response longer than one cycle");
    // A start pin rise in parallel arm mode opens sampling, not a measurement
    start_busy_a: assert property ($rose(meas_start_input) && !busy |->
        ##4 (busy || sampling)) else $error("busy missing after start");
    write_in_busy_a: assert property (link_valid && link_cmd == LINK_RESULT_WRITE |-> busy)
        else $error("busy dropped before result write");
    resp_ends_busy_a: assert property (resp_valid && $past(busy) |-> !busy)
        else $error("busy not released with response");
endmodule

//--- test/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import msq_pkg::*;
;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    msq_src_t src = SRC_PARALLEL;
    msq_arm_t arm = ARM_SERIAL;
    msq_route_t route = OUT_LINK;
    logic win = 1'b0, trig = 1'b0, done = 1'b0, sreq = 1'b0, creq = 1'b0, plost = 1'b0;
    logic [RES_W-1:0] val = 8'h00;
    logic [OBJ_W-1:0] otype = 4'h0;
    logic [PSEL_W-1:0] psel = 2'h0, mprog;
    logic [CODE_W-1:0] code = 8'h00;
    logic go, dbusy, sres_v, lw_v, prun, dflag, clr, samp, terr, rdy;
    logic [RES_W-1:0] sres, lw_d, dres;
    logic [OBJ_W-1:0] obj;
    logic [CODE_W-1:0] ecode;
    logic [TIME_W-1:0] mtime;
    int errors = 0, n_tests = 0, n_go = 0, n_done = 0, n_clr = 0, n_err = 0, n_sr = 0;
    int n_halt = 0, n_we = 0, n_lw = 0, eng = 0, i;

    always #2.5 clock = ~clock;

    msq_if bus_if ();
    msq_dev #(.CHG_CYCLES(4)) msq_dev_inst (.clock(clock), .nrst(nrst), .bus(bus_if.dev),
        .start_source_select(src), .sampling_arm_source(arm), .result_route(route),
        .trigger_window_set(win), .program_switch_en(1'b1), .trigger_event(trig),
        .meas_done(done), .meas_value(val), .meas_go(go), .object_type(obj),
        .meas_program(mprog), .meas_time(mtime), .logic_prog_run(prun),
        .measurement_done_flag(dflag), .aux_relay_clear(clr), .sampling(samp),
        .trigger_unconfigured_error(terr), .error_code(ecode));
    msq_host #(.HOLD_CYCLES(20)) msq_host_inst (.clock(clock), .nrst(nrst), .bus(bus_if.host),
        .start_req(sreq), .obj_type_req(otype), .prog_sel_req(psel), .seq_ready(rdy),
        .cmd_req(creq), .cmd_req_code(code), .serial_result_valid(sres_v),
        .serial_result_data(sres), .pc_power_lost(plost), .link_write_valid(lw_v),
        .link_write_data(lw_d), .dev_busy(dbusy), .dev_result(dres));
    msq_chk msq_chk_inst (.clock(clock), .nrst(nrst),
        .meas_start_input(bus_if.meas_start_input), .busy(bus_if.busy),
        .resp_valid(bus_if.resp_valid), .link_valid(bus_if.link_valid),
        .link_cmd(bus_if.link_cmd), .link_ack(bus_if.link_ack), .link_err(bus_if.link_err),
        .sampling(samp));

    // Measurement engine stand-in and event counters
    always @(posedge clock) begin
        done <= (eng == 1);
        if (go) eng <= 6;
        else if (eng > 0) eng <= eng - 1;
        if (go) n_go <= n_go + 1;
        if (dflag) n_done <= n_done + 1;
        if (clr) n_clr <= n_clr + 1;
        if (!prun) n_halt <= n_halt + 1;
        if (sres_v) n_sr <= n_sr + 1;
        if (bus_if.link_ack && bus_if.link_err == ERR_WRITE_MODE) n_err <= n_err + 1;
        if (bus_if.link_valid && bus_if.link_cmd == LINK_WRITE_ENABLE) n_we <= n_we + 1;
        if (lw_v) n_lw <= n_lw + 1;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic lim(input int k);
        if (k >= 300) begin
            errors++;
            $display("[FAIL] %0t wait timed out", $time);
            tally_and_finish();
        end
    endtask

    task automatic cmd(input logic [7:0] c);
        @(posedge clock);
        code <= c;
        creq <= 1'b1;
        @(posedge clock);
        creq <= 1'b0;
    endtask

    task automatic wdone(input int k);
        for (i = 0; i < 300 && n_done == k; i++) @(posedge clock);
        lim(i);
        for (i = 0; i < 300 && bus_if.busy !== 1'b0; i++) @(posedge clock);
        lim(i);
    endtask

    task automatic pstart(input logic [3:0] t, input logic [7:0] v);
        int k;
        k = n_done;
        @(posedge clock);
        otype <= t;
        val <= v;
        for (i = 0; i < 300 && rdy !== 1'b1; i++) @(posedge clock);
        lim(i);
        sreq <= 1'b1;
        @(posedge clock);
        sreq <= 1'b0;
        wdone(k);
        chk(n_done - k, 1);
    endtask

    task automatic par_link();
        int c, h;
        c = n_clr;
        h = n_halt;
        psel <= 2'h2;
        pstart(4'h3, 8'ha5);
        chk(n_clr - c, 1);
        chk(obj, 4'h3);
        chk(lw_d, 8'ha5);
        chk(dres, 8'ha5);
        chk(n_halt > h, 1);
        chk(mprog, 2'h2);
    endtask

    task automatic link_retry();
        int e, c, w;
        logic [31:0] t;
        e = n_err;
        c = n_clr;
        w = n_lw;
        t = mtime;
        @(posedge clock);
        plost <= 1'b1;
        @(posedge clock);
        plost <= 1'b0;
        pstart(4'h3, 8'h3c);
        chk(n_err - e, 1);
        chk(lw_d, 8'h3c);
        chk(n_lw - w, 1);
        chk(n_clr - c, 0);
        chk(t - mtime, 4);
    endtask

    task automatic serial_run();
        int k, g;
        @(posedge clock);
        src <= SRC_SERIAL;
        route <= OUT_SERIAL;
        for (int c = 8'h10; c <= 8'h13; c++) begin
            k = n_sr;
            g = n_go;
            val <= c[7:0] ^ 8'hf0;
            cmd(c[7:0]);
            cmd(8'h10);
            if (c != 8'h11) begin
                // Busy holds in the response state until the result is asked for
                for (i = 0; i < 300 && dflag !== 1'b1; i++) @(posedge clock);
                lim(i);
                cmd(CMD_RESULT);
            end
            for (i = 0; i < 300 && n_sr == k; i++) @(posedge clock);
            lim(i);
            chk(sres, c[7:0] ^ 8'hf0);
            chk(n_go - g, 1);
            for (i = 0; i < 300 && bus_if.busy !== 1'b0; i++) @(posedge clock);
            lim(i);
        end
    endtask

    task automatic trig_run();
        int w;
        w = n_we;
        @(posedge clock);
        route <= OUT_LINK;
        src <= SRC_TRIGGER;
        for (i = 0; i < 300 && n_we == w; i++) @(posedge clock);
        lim(i);
        chk(n_we - w, 1);
        cmd(8'h18);
        repeat (4) @(posedge clock);
        chk(samp, 1'b0);
        chk(terr, 1'b1);
        chk(ecode, ERR_TRIG_UNSET);
        win <= 1'b1;
        repeat (2) @(posedge clock);
        chk(samp, 1'b0);
        for (int c = 8'h18; c <= 8'h1b; c++) begin
            cmd(c[7:0]);
            for (i = 0; i < 300 && samp !== 1'b1; i++) @(posedge clock);
            chk(samp, 1'b1);
            cmd(c[7:0]);
            for (i = 0; i < 300 && samp !== 1'b0; i++) @(posedge clock);
            chk(samp, 1'b0);
        end
        val <= 8'h77;
        cmd(8'h19);
        for (i = 0; i < 300 && samp !== 1'b1; i++) @(posedge clock);
        lim(i);
        trig <= 1'b1;
        @(posedge clock);
        trig <= 1'b0;
        wdone(n_done);
        chk(lw_d, 8'h77);
        chk(samp, 1'b0);
    endtask

    task automatic par_arm();
        @(posedge clock);
        arm <= ARM_PARALLEL;
        route <= OUT_NONE;
        for (int r = 0; r < 2; r++) begin
            for (i = 0; i < 300 && rdy !== 1'b1; i++) @(posedge clock);
            lim(i);
            sreq <= 1'b1;
            @(posedge clock);
            sreq <= 1'b0;
            for (i = 0; i < 300 && samp !== 1'b1; i++) @(posedge clock);
            chk(samp, 1'b1);
            if (r == 0) begin
                trig <= 1'b1;
                @(posedge clock);
                trig <= 1'b0;
                wdone(n_done);
                // Start pin still high here: no rearm without a fresh rise
                chk({bus_if.meas_start_input, samp}, 2'b10);
            end else begin
                for (i = 0; i < 300 && samp !== 1'b0; i++) @(posedge clock);
                chk({bus_if.meas_start_input, samp}, 2'b00);
            end
        end
    endtask

    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        par_link();
        link_retry();
        serial_run();
        trig_run();
        par_arm();
        tally_and_finish();
    end
endmodule
